/* File: core/mobe_bright.sv */
// Effective brightness from internal sensor, external bus value or weighted mix
`timescale 1ns/1ps
module mobe_bright
    import mobe_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Configuration
    input  wire mobe_src_e   src,
    input  wire logic [4:0]  weight_idx,
    // Sensor values
    input  wire logic [15:0] int_lux,
    input  wire logic [15:0] ext_f16,
    input  wire logic        ext_wr,
    // Result
    output logic      [15:0] eff_lux
);

    typedef struct packed {
        logic [15:0] ext;
        logic [15:0] eff;
    } mobe_br_s;

    mobe_br_s q;
    mobe_br_s d;
    logic [4:0]  idx;
    logic [6:0]  w_ext;
    logic [23:0] mix;

    assign eff_lux = q.eff;

    always_comb begin
        d     = q;
        idx   = (weight_idx < WEIGHT_IDX_MIN) ? WEIGHT_IDX_MIN :
                (weight_idx > WEIGHT_IDX_MAX) ? WEIGHT_IDX_MAX : weight_idx;
        w_ext = 7'(idx * WEIGHT_STEP_PCT);
        mix   = (24'(int_lux) * 24'(PCT_FULL - w_ext) + 24'(q.ext) * 24'(w_ext)) / 24'(PCT_FULL);
        if (ext_wr) begin
            d.ext = f16_dec(ext_f16);
        end
        unique case (src)
            SRC_INT: d.eff = int_lux;
            SRC_EXT: d.eff = q.ext;
            SRC_MIX: d.eff = mix[15:0];
            default: d.eff = int_lux;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

endmodule

/* File: core/mobe_core.sv */
// Per function block: output object formats, sector OR, brightness and twilight gating
`timescale 1ns/1ps
// Functional notes
// - Output set to none is inactive and presents no object.
// - Switching mode sends 1-bit ON/OFF.
// - Staircase mode repeats 1-bit ON cyclically to retrigger run-on time.
// - Forced mode sends 2-bit value: priority bit plus ON/OFF.
// - Dimming mode sends a byte for 0 to 100 percent.
// - Scene mode sends a byte for scene numbers 1 to 64.
// - Temperature mode sends 2-byte float, 0 to 40 degrees, whole degrees.
// - Brightness mode sends 2-byte float, 0 to 2000 lux, 50 lux steps.
// - Controller mode sends a byte selecting the operating mode.
// - Extension unit offers no output objects at all.
// - Simple detector forces output one to 1-bit switching.
// - Simple detector leaves output two absent and unconfigurable.
// - Motion is the OR of assigned sectors out of three.
// - Brightness comes from internal, external or combined source.
// - Combined weighting in 5 percent steps from 95/5 to 5/95.
// - Independent evaluation ignores brightness; motion in idle starts detection.
// - Dependent evaluation accepts motion only below the effective twilight level.
// - Configured twilight level lies within 10 to 2000 lux, default 500.
// - Flag chooses whether reprogramming restores configured twilight level.
// - Configured level applies until a preset or teach happened.
// - Received preset becomes the level until next preset, teach or reprogramming with the flag set, survives bus loss.
module mobe_core
    import mobe_pkg::*;
#(
    parameter int unsigned MS_TICK_CYCLES = MS_CYCLES,
    parameter int unsigned STAIR_MS       = STAIR_PERIOD_MS
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Application configuration
    input  wire mobe_app_e   app_type,
    input  wire logic        app_detector,
    input  wire logic [2:0]  function_block_index,
    // Output object configuration
    input  wire mobe_func_e  out1_func,
    input  wire logic [7:0]  out1_val_on,
    input  wire logic [7:0]  out1_val_off,
    input  wire logic        out1_force_ctl,
    input  wire mobe_func_e  out2_func,
    input  wire logic [7:0]  out2_val_on,
    input  wire logic [7:0]  out2_val_off,
    input  wire logic        out2_force_ctl,
    // Sensor configuration
    input  wire logic [2:0]  sector_assign,
    input  wire mobe_src_e   bright_src,
    input  wire logic [4:0]  weight_idx,
    // Twilight configuration
    input  wire logic        eval_dependent,
    input  wire logic [15:0] tw_cfg_lux,
    input  wire logic        tw_overwrite,
    input  wire logic        preset_en,
    input  wire logic        teach_en,
    input  wire mobe_tpol_e  teach_pol,
    // Sensors
    input  wire logic [2:0]  pir_sector,
    input  wire logic [15:0] int_lux,
    // Received bus objects
    input  wire logic [15:0] ext_bright_f16,
    input  wire logic        ext_bright_wr,
    input  wire logic [15:0] tw_preset_f16,
    input  wire logic        tw_preset_wr,
    input  wire logic        teach_val,
    input  wire logic        teach_wr,
    input  wire logic        reprogram,
    // Detection engine
    input  wire logic        det_idle,
    input  wire logic        det_req,
    input  wire logic        det_on,
    // Evaluation results
    output logic             motion_raw,
    output logic             motion_acc,
    output logic             detect_start,
    output logic [15:0]      eff_lux,
    output logic [15:0]      tw_eff_lux,
    output logic             tw_ext_active,
    // Output object 1
    output logic             obj1_present,
    output logic             obj1_valid,
    output mobe_size_e       obj1_size,
    output logic [15:0]      obj1_data,
    // Output object 2
    output logic             obj2_present,
    output logic             obj2_valid,
    output mobe_size_e       obj2_size,
    output logic [15:0]      obj2_data
);

    typedef struct packed {
        logic [2:0]  pir_s1;
        logic [2:0]  pir_s2;
        logic [2:0]  pir_s3;
        logic [2:0]  pir;
        logic [16:0] tick_cnt;
        logic        tick;
        logic        motion;
        logic        acc;
        logic        start;
        logic [15:0] tw_ext;
        logic        tw_act;
        logic [15:0] tw_eff;
        logic        req;
        logic        on;
        mobe_func_e  f1;
        mobe_func_e  f2;
    } mobe_core_s;

    localparam mobe_core_s CORE_RESET = '{tw_ext: TW_DEFAULT_LUX, tw_eff: TW_DEFAULT_LUX, f1: FN_NONE,
                                          f2: FN_NONE, default: '0};

    mobe_core_s q;
    mobe_core_s d;
    logic [15:0] eff_w;
    logic [15:0] tw_cfg_clamped;
    logic        teach_active;
    logic        raw_now;
    logic        acc_now;

    mobe_tx_if tx1_if ();
    mobe_tx_if tx2_if ();

    // Brightness source selection and weighting
    mobe_bright u_bright (
        .clk        (clk),
        .rst        (rst),
        .src        (bright_src),
        .weight_idx (weight_idx),
        .int_lux    (int_lux),
        .ext_f16    (ext_bright_f16),
        .ext_wr     (ext_bright_wr),
        .eff_lux    (eff_w)
    );

    mobe_tx u_tx1 (
        .clk (clk),
        .rst (rst),
        .tx  (tx1_if.enc)
    );

    mobe_tx u_tx2 (
        .clk (clk),
        .rst (rst),
        .tx  (tx2_if.enc)
    );

    assign tx1_if.tick      = q.tick;
    assign tx1_if.req       = q.req;
    assign tx1_if.on        = q.on;
    assign tx1_if.force_ctl = out1_force_ctl;
    assign tx1_if.func      = q.f1;
    assign tx1_if.val_on    = out1_val_on;
    assign tx1_if.val_off   = out1_val_off;
    assign tx1_if.period_ms = 16'(STAIR_MS);
    assign tx2_if.tick      = q.tick;
    assign tx2_if.req       = q.req;
    assign tx2_if.on        = q.on;
    assign tx2_if.force_ctl = out2_force_ctl;
    assign tx2_if.func      = q.f2;
    assign tx2_if.val_on    = out2_val_on;
    assign tx2_if.val_off   = out2_val_off;
    assign tx2_if.period_ms = 16'(STAIR_MS);

    assign motion_raw    = q.motion;
    assign motion_acc    = q.acc;
    assign detect_start  = q.start;
    assign eff_lux       = eff_w;
    assign tw_eff_lux    = q.tw_eff;
    assign tw_ext_active = q.tw_act;
    assign obj1_present  = tx1_if.present;
    assign obj1_valid    = tx1_if.valid;
    assign obj1_size     = tx1_if.size;
    assign obj1_data     = tx1_if.data;
    assign obj2_present  = tx2_if.present;
    assign obj2_valid    = tx2_if.valid;
    assign obj2_size     = tx2_if.size;
    assign obj2_data     = tx2_if.data;

    always_comb begin
        d = q;

        // Sector pins are asynchronous; a change counts once stages two and three agree
        d.pir_s1 = pir_sector;
        d.pir_s2 = q.pir_s1;
        d.pir_s3 = q.pir_s2;
        for (int i = 0; i < 3; i++) begin
            if (q.pir_s2[i] == q.pir_s3[i]) begin
                d.pir[i] = q.pir_s3[i];
            end
        end

        // Millisecond enable
        d.tick = 1'b0;
        if (q.tick_cnt >= 17'(MS_TICK_CYCLES - 1)) begin
            d.tick_cnt = 17'h00000;
            d.tick     = 1'b1;
        end else begin
            d.tick_cnt = q.tick_cnt + 17'h00001;
        end

        // Output object availability per application
        if (app_type == APP_EXT) begin
            d.f1 = FN_NONE;
            d.f2 = FN_NONE;
        end else if (app_detector) begin
            d.f1 = FN_SWITCH;
            d.f2 = FN_NONE;
        end else begin
            d.f1 = out1_func;
            d.f2 = out2_func;
        end
        d.req = det_req;
        d.on  = det_on;

        // Configured level clamped to its legal span
        tw_cfg_clamped = (tw_cfg_lux < TW_MIN_LUX) ? TW_MIN_LUX :
                         (tw_cfg_lux > TW_MAX_LUX) ? TW_MAX_LUX : tw_cfg_lux;
        unique case (teach_pol)
            TP_ONE:  teach_active = teach_val;
            TP_ZERO: teach_active = !teach_val;
            TP_BOTH: teach_active = 1'b1;
            default: teach_active = 1'b0;
        endcase
        // Clears come first so that a preset or teach in the same cycle wins
        if (reprogram && tw_overwrite) begin
            d.tw_act = 1'b0;
        end
        if (teach_en && teach_wr && !teach_active && teach_pol != TP_BOTH) begin
            d.tw_act = 1'b0;
        end
        if (preset_en && tw_preset_wr) begin
            d.tw_ext = f16_dec(tw_preset_f16);
            d.tw_act = 1'b1;
        end
        if (teach_en && teach_wr && teach_active) begin
            d.tw_ext = eff_w;
            d.tw_act = 1'b1;
        end
        d.tw_eff = q.tw_act ? q.tw_ext : tw_cfg_clamped;

        // Motion gating
        raw_now  = |(q.pir & sector_assign);
        acc_now  = eval_dependent ? (raw_now && (eff_w < q.tw_eff)) : raw_now;
        d.motion = raw_now;
        d.acc    = acc_now;
        // One pulse per idle period; the engine leaves idle on the pulse
        d.start  = acc_now && det_idle && !q.start;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            q <= CORE_RESET;
        end else begin
            q <= d;
        end
    end

endmodule

/* File: core/mobe_pkg.sv */
// Shared constants, types and conversion functions of the motion/brightness evaluation block
package mobe_pkg;

    localparam int unsigned CLK_PERIOD_NS   = 10;
    localparam int unsigned TICK_PERIOD_NS  = 1000000;
    localparam int unsigned MS_CYCLES       = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned STAIR_PERIOD_S  = 60;
    localparam int unsigned STAIR_PERIOD_MS = STAIR_PERIOD_S * 1000;

    localparam logic [15:0] TW_MIN_LUX      = 16'h000A;
    localparam logic [15:0] TW_MAX_LUX      = 16'h07D0;
    localparam logic [15:0] TW_DEFAULT_LUX  = 16'h01F4;
    localparam logic [4:0]  WEIGHT_IDX_MIN  = 5'h01;
    localparam logic [4:0]  WEIGHT_IDX_MAX  = 5'h13;
    localparam logic [6:0]  WEIGHT_STEP_PCT = 7'h05;
    localparam logic [6:0]  PCT_FULL        = 7'h64;
    localparam logic [7:0]  DIM_MAX_PCT     = 8'h64;
    localparam logic [15:0] DIM_FULL_CODE   = 16'h00FF;
    localparam logic [7:0]  SCENE_MIN       = 8'h01;
    localparam logic [7:0]  SCENE_MAX       = 8'h40;
    localparam logic [7:0]  TEMP_MAX_C      = 8'h28;
    localparam logic [7:0]  LUX_STEPS_MAX   = 8'h28;
    localparam logic [19:0] LUX_STEP        = 20'h00032;
    localparam logic [19:0] F16_SCALE       = 20'h00064;
    localparam logic [7:0]  OPMODE_MAX      = 8'h04;

    typedef enum logic [3:0] {
        FN_NONE   = 4'h0,
        FN_SWITCH = 4'h1,
        FN_STAIR  = 4'h2,
        FN_FORCED = 4'h3,
        FN_DIM    = 4'h4,
        FN_SCENE  = 4'h5,
        FN_TEMP   = 4'h6,
        FN_LUX    = 4'h7,
        FN_OPMODE = 4'h8
    } mobe_func_e;

    typedef enum logic [1:0] {APP_SINGLE = 2'h0, APP_MAIN = 2'h1, APP_EXT = 2'h2} mobe_app_e;
    typedef enum logic [1:0] {SRC_INT = 2'h0, SRC_EXT = 2'h1, SRC_MIX = 2'h2} mobe_src_e;
    typedef enum logic [1:0] {TP_ONE = 2'h0, TP_ZERO = 2'h1, TP_BOTH = 2'h2} mobe_tpol_e;
    typedef enum logic [1:0] {SZ_1BIT = 2'h0, SZ_2BIT = 2'h1, SZ_1BYTE = 2'h2, SZ_2BYTE = 2'h3} mobe_size_e;

    // Bus float: value = mantissa * 2^exp * 0.01; negative values read as zero
    function automatic logic [15:0] f16_dec(input logic [15:0] f);
        logic [26:0] v;
        v = ({16'h0000, f[10:0]} << f[14:11]) / 27'(F16_SCALE);
        if (f[15])
            return 16'h0000;
        return (v > 27'h000FFFF) ? 16'hFFFF : v[15:0];
    endfunction

    function automatic logic [15:0] f16_enc(input logic [19:0] hundredths);
        logic [19:0] m;
        logic [3:0]  e;
        m = hundredths;
        e = 4'h0;
        for (int i = 0; i < 9; i++) begin
            if (m > 20'h007FF) begin
                m = m >> 1;
                e = e + 4'h1;
            end
        end
        return {1'b0, e, m[10:0]};
    endfunction

endpackage

/* File: core/mobe_tx.sv */
// Telegram encoder for one output object, including cyclic staircase repetition
`timescale 1ns/1ps
module mobe_tx
    import mobe_pkg::*;
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Core side
    mobe_tx_if.enc    tx
);

    typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_HOLD = 2'b01} mobe_tx_st_e;

    typedef struct packed {
        mobe_tx_st_e st;
        logic [15:0] cnt;
        logic        present;
        logic        valid;
        mobe_size_e  size;
        logic [15:0] data;
    } mobe_tx_s;

    localparam mobe_tx_s TX_RESET = '{st: ST_IDLE, size: SZ_1BIT, default: '0};

    mobe_tx_s q;
    mobe_tx_s d;
    logic [7:0] v;
    logic       send;

    assign tx.present = q.present;
    assign tx.valid   = q.valid;
    assign tx.size    = q.size;
    assign tx.data    = q.data;

    always_comb begin
        d         = q;
        d.valid   = 1'b0;
        d.present = (tx.func != FN_NONE);
        v         = tx.on ? tx.val_on : tx.val_off;
        send      = tx.req;
        if (tx.func != FN_STAIR) begin
            d.st = ST_IDLE;
        end else if (tx.req) begin
            d.st  = tx.on ? ST_HOLD : ST_IDLE;
            d.cnt = 16'h0000;
        end else if (q.st == ST_HOLD && tx.tick) begin
            // Repeat ON to retrigger the actuator's run-on timer
            if (q.cnt >= tx.period_ms - 16'h0001) begin
                d.cnt = 16'h0000;
                send  = 1'b1;
            end else begin
                d.cnt = q.cnt + 16'h0001;
            end
        end
        if (send && tx.func != FN_NONE) begin
            d.valid = 1'b1;
            unique case (tx.func)
                FN_SWITCH, FN_STAIR: begin
                    d.size = SZ_1BIT;
                    d.data = {15'h0000, tx.on};
                end
                FN_FORCED: begin
                    d.size = SZ_2BIT;
                    d.data = {14'h0000, tx.force_ctl, tx.on};
                end
                FN_DIM: begin
                    d.size = SZ_1BYTE;
                    d.data = 16'(({8'h00, (v > DIM_MAX_PCT) ? DIM_MAX_PCT : v} * DIM_FULL_CODE)
                                 / {8'h00, DIM_MAX_PCT});
                end
                FN_SCENE: begin
                    d.size = SZ_1BYTE;
                    d.data = {8'h00, ((v < SCENE_MIN) ? SCENE_MIN : (v > SCENE_MAX) ? SCENE_MAX : v)
                                     - SCENE_MIN};
                end
                FN_TEMP: begin
                    d.size = SZ_2BYTE;
                    d.data = f16_enc(20'((v > TEMP_MAX_C) ? TEMP_MAX_C : v) * F16_SCALE);
                end
                FN_LUX: begin
                    d.size = SZ_2BYTE;
                    d.data = f16_enc(20'((v > LUX_STEPS_MAX) ? LUX_STEPS_MAX : v) * LUX_STEP * F16_SCALE);
                end
                FN_OPMODE: begin
                    d.size = SZ_1BYTE;
                    d.data = {8'h00, (v > OPMODE_MAX) ? 8'h00 : v};
                end
                default: begin
                    d.valid = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            q <= TX_RESET;
        end else begin
            q <= d;
        end
    end

endmodule

/* File: core/mobe_tx_if.sv */
// Link between the evaluation core and one output-object telegram encoder
`timescale 1ns/1ps
interface mobe_tx_if;
    import mobe_pkg::*;
    logic        tick;
    logic        req;
    logic        on;
    logic        force_ctl;
    mobe_func_e  func;
    logic [7:0]  val_on;
    logic [7:0]  val_off;
    logic [15:0] period_ms;
    logic        present;
    logic        valid;
    mobe_size_e  size;
    logic [15:0] data;

    modport ctl (output tick, req, on, force_ctl, func, val_on, val_off, period_ms,
                 input present, valid, size, data);
    modport enc (input tick, req, on, force_ctl, func, val_on, val_off, period_ms,
                 output present, valid, size, data);
endinterface

/* File: verif/mobe_bus_partner.sv */
// Bus-side receiver that logs the telegrams of one output object
`timescale 1ns/1ps
module mobe_bus_partner
    import mobe_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Telegram from the device
    input  wire logic        valid,
    input  wire mobe_size_e  size,
    input  wire logic [15:0] data,
    // Log
    output logic       [7:0] count,
    output logic      [17:0] last
);
    // Counts telegrams instead of timing run-on
    always_ff @(posedge clk) begin
        if (rst)
            count <= 8'h00;
        else if (valid)
            count <= count + 8'h01;
        if (valid)
            last <= {size, data};
    end
endmodule

/* File: verif/mobe_core_monitor.sv */
// Port-level assertions of the evaluation core
`timescale 1ns/1ps
module mobe_core_monitor
    import mobe_pkg::*;
(
    // Clock, reset and configuration
    input wire logic        clk,
    input wire logic        rst,
    input wire mobe_app_e   app_type,
    input wire logic        app_detector,
    input wire logic        eval_dependent,
    input wire logic [15:0] tw_cfg_lux,
    // Results
    input wire logic        motion_raw,
    input wire logic        motion_acc,
    input wire logic        detect_start,
    input wire logic [15:0] eff_lux,
    input wire logic [15:0] tw_eff_lux,
    input wire logic        tw_ext_active,
    input wire logic        obj1_present,
    input wire logic        obj1_valid,
    input wire mobe_size_e  obj1_size,
    input wire logic        obj2_present,
    input wire logic        obj2_valid
);
    logic [2:0]  cyc_q;
    logic [15:0] lim;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // Configured level (clamped) checked once four cycles have passed since reset
    always_ff @(posedge clk) begin
        if (rst)
            cyc_q <= 3'h0;
        else if (!cyc_q[2])
            cyc_q <= cyc_q + 3'h1;
    end
    assign lim = (tw_cfg_lux < TW_MIN_LUX) ? TW_MIN_LUX : (tw_cfg_lux > TW_MAX_LUX) ? TW_MAX_LUX : tw_cfg_lux;

    a_valid_present: assert property ((obj1_valid -> obj1_present) && (obj2_valid -> obj2_present))
        else $error("telegram from absent object");
    a_ext_absent: assert property (app_type == APP_EXT && $past(app_type) == APP_EXT
        && $past(app_type, 2) == APP_EXT |-> !obj1_present && !obj2_present) else $error("extension shows objects");
    a_det_out2: assert property (app_detector && $past(app_detector) && $past(app_detector, 2)
        |-> !obj2_present) else $error("second output in detector");
    a_det_switch: assert property (obj1_valid && app_detector && $past(app_detector, 3)
        |-> obj1_size == SZ_1BIT) else $error("detector output not 1-bit");
    a_indep_pass: assert property (!eval_dependent && !$past(eval_dependent)
        |-> motion_acc == motion_raw) else $error("independent mode gated motion");
    a_start_pulse: assert property (detect_start |-> motion_acc ##1 !detect_start)
        else $error("start not a pulse of accepted motion");
    a_dep_gate: assert property (motion_acc && eval_dependent && $past(eval_dependent)
        && $stable(eff_lux) && $stable(tw_eff_lux) |-> eff_lux < tw_eff_lux) else $error("motion above level");
    a_tw_config: assert property (cyc_q[2] && !tw_ext_active && !$past(tw_ext_active)
        && $stable(tw_cfg_lux) |-> tw_eff_lux == lim) else $error("configured level not in use");
endmodule

bind mobe_core mobe_core_monitor u_mon (.*);

/* File: verif/mobe_core_tb.sv */
// Self-checking bench of the evaluation core
`timescale 1ns/1ps
module mobe_core_tb;
    import mobe_pkg::*;
    localparam int unsigned STAIR = 3;
    logic        clk, rst, app_detector, out1_force_ctl, out2_force_ctl, eval_dependent, tw_overwrite;
    logic        preset_en, teach_en, ext_bright_wr, tw_preset_wr, teach_val, teach_wr, reprogram, det_idle;
    logic        det_req, det_on, motion_raw, motion_acc, detect_start, tw_ext_active, got, st, e;
    logic        obj1_present, obj1_valid, obj2_present, obj2_valid;
    logic [2:0]  function_block_index, sector_assign, pir_sector;
    logic [4:0]  weight_idx;
    logic [7:0]  out1_val_on, out1_val_off, out2_val_on, out2_val_off, cnt1, cnt2, v;
    logic [15:0] tw_cfg_lux, int_lux, ext_bright_f16, tw_preset_f16, eff_lux, tw_eff_lux, obj1_data, obj2_data;
    logic [17:0] l1, l2;
    mobe_app_e   app_type;
    mobe_func_e  out1_func, out2_func;
    mobe_src_e   bright_src;
    mobe_tpol_e  teach_pol;
    mobe_size_e  obj1_size, obj2_size;
    int          errors, comparisons, seed, i, k, n;

    mobe_core #(.MS_TICK_CYCLES(10), .STAIR_MS(STAIR)) dut (.*);
    mobe_bus_partner p1 (.clk(clk), .rst(rst), .valid(obj1_valid), .size(obj1_size), .data(obj1_data),
                         .count(cnt1), .last(l1));
    mobe_bus_partner p2 (.clk(clk), .rst(rst), .valid(obj2_valid), .size(obj2_size), .data(obj2_data),
                         .count(cnt2), .last(l2));

    task automatic chk(input string w, input logic [19:0] x, input logic [19:0] y);
        comparisons++;
        if (y !== x) begin
            errors++;
            $display("CHECK FAILED %s expected %0h seen %0h", w, x, y);
        end
    endtask

    task automatic final_report;
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic tick(input int c);
        repeat (c) @(negedge clk);
    endtask

    // Four cycles cover the three-edge answer
    task automatic send(input logic on, input logic sel);
        logic [7:0] c;
        c = sel ? cnt2 : cnt1;
        det_on = on;
        det_req = 1'b1;
        tick(1);
        det_req = 1'b0;
        tick(4);
        got = (sel ? cnt2 : cnt1) != c;
    endtask

    function automatic logic [15:0] fl(input logic [19:0] h);
        logic [3:0] x;
        x = 4'h0;
        while ((h >> x) > 20'h007FF)
            x++;
        return {1'b0, x, 11'(h >> x)};
    endfunction

    function automatic logic [17:0] expv(input mobe_func_e f, input logic [7:0] b, input logic on, input logic c);
        logic [19:0] w;
        w = (b > 8'h28) ? 20'h00028 : {12'h000, b};
        case (f)
            FN_FORCED: return {SZ_2BIT, 14'h0000, c, on};
            FN_DIM:    return {SZ_1BYTE, 16'(((b > 8'h64) ? 20'h00064 : {12'h000, b}) * 20'h000FF / 20'h00064)};
            FN_SCENE:  return {SZ_1BYTE, 8'h00, (b < 8'h01) ? 8'h00 : (b > 8'h40) ? 8'h3F : b - 8'h01};
            FN_TEMP:   return {SZ_2BYTE, fl(w * 20'h00064)};
            FN_LUX:    return {SZ_2BYTE, fl(w * 20'h01388)};
            FN_OPMODE: return {SZ_1BYTE, 8'h00, (b > 8'h04) ? 8'h00 : b};
            default:   return {SZ_1BIT, 15'h0000, on};
        endcase
    endfunction

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial begin
        {app_detector, out1_force_ctl, out2_force_ctl, eval_dependent, tw_overwrite, preset_en, teach_en} = '0;
        {ext_bright_wr, tw_preset_wr, teach_val, teach_wr, reprogram, det_req, det_on, sector_assign} = '0;
        {function_block_index, pir_sector, weight_idx, out1_val_on, out1_val_off, out2_val_on} = '0;
        {out2_val_off, tw_cfg_lux, int_lux, ext_bright_f16, tw_preset_f16} = '0;
        {rst, det_idle} = 2'h3;
        app_type = APP_MAIN;
        out1_func = FN_NONE;
        out2_func = FN_NONE;
        bright_src = SRC_INT;
        teach_pol = TP_ONE;
        seed = 67625;
        errors = 0;
        comparisons = 0;
        tick(2);
        rst = 1'b0;
        tick(1);
        // Every function, extreme bytes first, then random ones
        for (i = 0; i < 27; i++) begin
            out2_func = mobe_func_e'(i % 9);
            out2_val_on = (i < 9) ? 8'hFF : 8'($random(seed));
            out2_val_off = (i < 9) ? 8'h00 : 8'($random(seed));
            out2_force_ctl = i[1];
            v = 8'($random(seed));
            tick(1);
            send(v[0], 1'b1);
            chk("o2 present", out2_func != FN_NONE, obj2_present);
            chk("o2 sent", out2_func != FN_NONE, got);
            n = expv(out2_func, det_on ? out2_val_on : out2_val_off, det_on, out2_force_ctl);
            if (got)
                chk("o2 telegram", n, l2);
        end
        out1_func = FN_STAIR;
        tick(1);
        send(1'b1, 1'b0);
        k = cnt1;
        tick(STAIR * 30 + 10);
        chk("stair repeat", 1'b1, 8'(cnt1 - k) >= 8'h02);
        chk("stair on", 18'h00001, l1);
        send(1'b0, 1'b0);
        k = cnt1;
        tick(100);
        chk("stair stop", 18'(k), cnt1);
        chk("stair off", 18'h00000, l1);
        app_type = APP_EXT;
        tick(2);
        send(1'b1, 1'b0);
        chk("ext objects", 3'h0, {obj1_present, obj2_present, got});
        {app_type, app_detector, out1_func, out2_func} = {APP_SINGLE, 1'b1, FN_SCENE, FN_DIM};
        tick(2);
        send(1'b1, 1'b0);
        chk("detector", {1'b0, SZ_1BIT, 16'h0001}, {obj2_present, l1});
        {app_type, app_detector} = {APP_MAIN, 1'b0};
        // External floats chosen so 4*k lux decodes exactly
        for (i = 0; i < 12; i++) begin
            bright_src = mobe_src_e'(i % 3);
            weight_idx = (i < 6) ? 5'h01 : (i < 9) ? 5'h13 : 5'(1 + {$random(seed)} % 19);
            int_lux = 16'({$random(seed)} % 4000);
            k = 1 + {$random(seed)} % 81;
            ext_bright_f16 = {5'h04, 11'(25 * k)};
            ext_bright_wr = 1'b1;
            tick(1);
            ext_bright_wr = 1'b0;
            tick(3);
            n = (i % 3 == 0) ? int_lux : (i % 3 == 1) ? 4 * k : (int_lux * (100 - 5 * weight_idx) + 20 * k * weight_idx) / 100;
            chk("eff_lux", n, eff_lux);
        end
        bright_src = SRC_INT;
        for (i = 0; i < 3; i++) begin
            tw_cfg_lux = (i == 0) ? 16'h0005 : (i == 1) ? 16'h0FA0 : 16'h0320;
            tick(3);
            chk("tw cfg", (i == 0) ? TW_MIN_LUX : (i == 1) ? TW_MAX_LUX : 16'h0320, tw_eff_lux);
        end
        // Sectors hit and missed, brightness under and at level
        for (i = 0; i < 8; i++) begin
            eval_dependent = i[2];
            det_idle = (i != 2);
            sector_assign = 3'h1 << (i % 3);
            pir_sector = i[1] ? sector_assign : ~sector_assign;
            int_lux = i[0] ? 16'h0320 : 16'h031F;
            e = |(pir_sector & sector_assign);
            st = 1'b0;
            for (k = 0; k < 10; k++) begin
                tick(1);
                st = st | detect_start;
            end
            chk("motion", e, motion_raw);
            chk("accept", e && !(i[2] && i[0]), motion_acc);
            chk("start", e && !(i[2] && i[0]) && i != 2, st);
            pir_sector = 3'h0;
            tick(8);
        end
        preset_en = 1'b1;
        for (i = 0; i < 2; i++) begin
            tw_overwrite = i[0];
            k = 1 + {$random(seed)} % 81;
            tw_preset_f16 = {5'h04, 11'(25 * k)};
            tw_preset_wr = 1'b1;
            tick(1);
            tw_preset_wr = 1'b0;
            tick(3);
            chk("tw preset", {1'b1, 16'(4 * k)}, {tw_ext_active, tw_eff_lux});
            reprogram = 1'b1;
            tick(1);
            reprogram = 1'b0;
            tick(3);
            chk("tw reprogram", {!i[0], i[0] ? 16'h0320 : 16'(4 * k)}, {tw_ext_active, tw_eff_lux});
        end
        final_report;
    end
endmodule
